// ==== hw/ipb_pkg.sv ====
// ==========================================================================
// shared constants and types of the interrupt priority bank
package ipb_pkg;

    // sizes
    localparam int NUM_REGS   = 7;
    localparam int NUM_FIELDS = 19;
    localparam int FIELD_W    = 3;
    localparam int DATA_W     = 32;
    localparam int REG_W      = 16;
    localparam int ADDR_W     = 5;
    localparam int BE_W       = 4;
    localparam int BYTE_W     = 8;

    // priority codes
    localparam logic [FIELD_W-1:0] PRIO_OFF   = 3'h0;
    localparam logic [FIELD_W-1:0] PRIO_MIN   = 3'h1;
    localparam logic [FIELD_W-1:0] PRIO_RESET = 3'h4;
    localparam logic [FIELD_W-1:0] PRIO_MAX   = 3'h7;

    // register byte offsets, in register index order
    localparam logic [ADDR_W-1:0] OFS_ADC12    = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_PWM12    = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_PWM3_6   = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_PWM7_CMP = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_CMP34    = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_ADC01    = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_ADC2_5   = 5'h18;

    // implemented bits of each register
    localparam logic [REG_W-1:0] REG_MASK [NUM_REGS] = '{
        16'h0070, 16'h7700, 16'h7777, 16'h7777, 16'h0077, 16'h7700, 16'h7777};

    // owning register of each field: adc12, pwm1..9, cmp2..4, adc0..5
    localparam logic [2:0] FIELD_REG [NUM_FIELDS] = '{
        3'h0,
        3'h1, 3'h1,
        3'h2, 3'h2, 3'h2, 3'h2,
        3'h3, 3'h3, 3'h3, 3'h3,
        3'h4, 3'h4,
        3'h5, 3'h5,
        3'h6, 3'h6, 3'h6, 3'h6};

    // lowest bit of each field inside its register
    localparam logic [3:0] FIELD_LSB [NUM_FIELDS] = '{
        4'h4,
        4'h8, 4'hC,
        4'h0, 4'h4, 4'h8, 4'hC,
        4'h0, 4'h4, 4'h8, 4'hC,
        4'h0, 4'h4,
        4'h8, 4'hC,
        4'h0, 4'h4, 4'h8, 4'hC};

    // avalon answer codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACK  = 2'b01
    } ipb_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [BE_W-1:0]   byteenable;
        logic [DATA_W-1:0] writedata;
    } ipb_avs_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic [1:0]        response;
        logic              waitrequest;
    } ipb_avs_rsp_s;

    typedef struct packed {
        logic       hit;
        logic [2:0] idx;
    } ipb_dec_s;

    // last member sits at the low end: field index 0 is adc_p12
    typedef struct packed {
        logic [FIELD_W-1:0] adc_p5_done_level;
        logic [FIELD_W-1:0] adc_p4_done_level;
        logic [FIELD_W-1:0] adc_p3_done_level;
        logic [FIELD_W-1:0] adc_p2_done_level;
        logic [FIELD_W-1:0] adc_p1_done_level;
        logic [FIELD_W-1:0] adc_p0_done_level;
        logic [FIELD_W-1:0] comparator4_level;
        logic [FIELD_W-1:0] comparator3_level;
        logic [FIELD_W-1:0] comparator2_level;
        logic [FIELD_W-1:0] pwm_gen9_level;
        logic [FIELD_W-1:0] pwm_gen8_level;
        logic [FIELD_W-1:0] pwm_gen7_level;
        logic [FIELD_W-1:0] pwm_gen6_level;
        logic [FIELD_W-1:0] pwm_gen5_level;
        logic [FIELD_W-1:0] pwm_gen4_level;
        logic [FIELD_W-1:0] pwm_gen3_level;
        logic [FIELD_W-1:0] pwm_gen2_level;
        logic [FIELD_W-1:0] pwm_gen1_level;
        logic [FIELD_W-1:0] adc_p12_done_level;
    } ipb_levels_s;

    typedef logic [NUM_FIELDS-1:0] ipb_enables_t;

    typedef struct packed {
        ipb_state_e   st;
        logic         boot_done;
        ipb_avs_rsp_s rsp;
    } ipb_bank_s;

    typedef struct packed {
        logic [FIELD_W-1:0] level;
        logic               enabled;
    } ipb_field_s;

endpackage

// ==== hw/ipb_prio_field.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// one three-bit priority field with its enable flag
module ipb_prio_field (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    // write port
    input  wire logic                        wr_en,
    input  wire logic [ipb_pkg::FIELD_W-1:0] wr_level,
    // field state
    output logic      [ipb_pkg::FIELD_W-1:0] level_q,
    output logic                             enabled_q
);
    import ipb_pkg::*;

    ipb_field_s q;
    ipb_field_s d;

    // next value: a write replaces the code, zero means disabled
    always_comb begin
        d = q;
        if (wr_en) begin
            d.level   = wr_level;
            d.enabled = (wr_level != PRIO_OFF);
        end
    end

    // storage, loaded with level four at reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q.level   <= PRIO_RESET;
            q.enabled <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign level_q   = q.level;
    assign enabled_q = q.enabled;

    // ======================================================================
    // checks
    a_write_lands: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_en |=> level_q == $past(wr_level))
        else $error("priority write not stored");

    a_field_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
        !wr_en |=> $stable(level_q) && $stable(enabled_q))
        else $error("priority field changed without write");

    a_zero_disables: assert property (@(posedge clk_sys) disable iff (!rstn)
        enabled_q == (level_q != PRIO_OFF))
        else $error("enable flag disagrees with code");

    a_top_code: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_en && wr_level == PRIO_MAX |=> enabled_q && level_q == PRIO_MAX)
        else $error("code seven not taken as level seven");

    a_low_code: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_en && wr_level == PRIO_MIN |=> enabled_q && level_q == PRIO_MIN)
        else $error("code one not taken as level one");

endmodule
`default_nettype wire

// ==== hw/ipb_prio_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - each field is three bits; code seven gives the highest level seven
// - code zero disables the source so it is never granted
// - code one is level one; each code maps to its binary value
// - unimplemented bits read zero and ignore writes
// - reset loads each field with binary one-zero-zero
// - fields are read-write and read back the last written or reset value
// - adc pair twelve priority sits at bits six to four
// - pwm two at bits 14-12, pwm one at 10-8, low byte unused
// - pwm six, five, four, three at 14-12, 10-8, 6-4, 2-0
// - comparator two at 14-12; pwm nine, eight, seven below it
// - comparator four at 6-4, comparator three at 2-0, upper unused
// - adc pair one at 14-12, pair zero at 10-8, low byte unused
// - adc pairs five, four, three, two at 14-12, 10-8, 6-4, 2-0
// - after reset every source covered here sits at level four
module ipb_prio_bank (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // avalon-mm slave
    input  wire ipb_pkg::ipb_avs_req_s avs_req,
    output ipb_pkg::ipb_avs_rsp_s      avs_rsp,
    // priorities to the arbiter
    output ipb_pkg::ipb_levels_s       levels,
    output ipb_pkg::ipb_enables_t      src_enabled
);
    import ipb_pkg::*;

    // ======================================================================
    // address decode

    // maps a byte address onto a register index
    function automatic ipb_dec_s decode_reg(input logic [ADDR_W-1:0] addr);
        ipb_dec_s r;
        r.hit = 1'b1;
        r.idx = 3'h0;
        if (addr == OFS_ADC12) begin
            r.idx = 3'h0;
        end else if (addr == OFS_PWM12) begin
            r.idx = 3'h1;
        end else if (addr == OFS_PWM3_6) begin
            r.idx = 3'h2;
        end else if (addr == OFS_PWM7_CMP) begin
            r.idx = 3'h3;
        end else if (addr == OFS_CMP34) begin
            r.idx = 3'h4;
        end else if (addr == OFS_ADC01) begin
            r.idx = 3'h5;
        end else if (addr == OFS_ADC2_5) begin
            r.idx = 3'h6;
        end else begin
            r.hit = 1'b0;
        end
        return r;
    endfunction

    // ======================================================================
    // declarations

    ipb_bank_s                 q;
    ipb_bank_s                 d;
    ipb_dec_s                  dec;
    logic                      wr_fire;
    logic [DATA_W-1:0]         rd_word;
    logic [FIELD_W-1:0]        lvl     [NUM_FIELDS];
    logic [NUM_FIELDS-1:0]     fld_en;
    logic [NUM_FIELDS-1:0]     fld_wr;
    logic [NUM_FIELDS*FIELD_W-1:0] lvl_flat;

    // decode of the address the master currently holds
    assign dec = decode_reg(avs_req.address);

    // write takes effect at the edge where waitrequest is seen low
    assign wr_fire = (q.st == ST_ACK) && avs_req.write && dec.hit;

    // ======================================================================
    // priority fields

    // one field per source, placed by the package tables
    generate
        for (genvar i = 0; i < NUM_FIELDS; i++) begin : g_field
            localparam int LANE = int'(FIELD_LSB[i]) / BYTE_W;

            // byte enable of the lane that holds this field
            assign fld_wr[i] = wr_fire
                && (dec.idx == FIELD_REG[i])
                && avs_req.byteenable[LANE];

            ipb_prio_field u_field (
                .clk_sys   (clk_sys),
                .rstn      (rstn),
                .wr_en     (fld_wr[i]),
                .wr_level  (avs_req.writedata[FIELD_LSB[i] +: FIELD_W]),
                .level_q   (lvl[i]),
                .enabled_q (fld_en[i])
            );

            assign lvl_flat[i*FIELD_W +: FIELD_W] = lvl[i];
        end
    endgenerate

    // field flops go straight to the arbiter
    assign levels      = ipb_levels_s'(lvl_flat);
    assign src_enabled = fld_en;

    // ======================================================================
    // read data

    // gather the fields of the addressed register
    always_comb begin
        rd_word = '0;
        if (dec.hit) begin
            for (int i = 0; i < NUM_FIELDS; i++) begin
                if (FIELD_REG[i] == dec.idx) begin
                    rd_word[FIELD_LSB[i] +: FIELD_W] = lvl[i];
                end
            end
            // unused positions forced low
            rd_word[REG_W-1:0] = rd_word[REG_W-1:0] & REG_MASK[dec.idx];
        end
    end

    // ======================================================================
    // bus state machine

    // idle takes a request, ack answers it for exactly one cycle
    always_comb begin
        d = q;
        d.boot_done = 1'b1;
        case (q.st)
            ST_IDLE: begin
                if (avs_req.read || avs_req.write) begin
                    d.st              = ST_ACK;
                    d.rsp.waitrequest = 1'b0;
                    d.rsp.readdata    = avs_req.read ? rd_word : '0;
                    d.rsp.response    = dec.hit ? RESP_OKAY : RESP_DECERR;
                end
            end
            ST_ACK: begin
                d.st              = ST_IDLE;
                d.rsp.waitrequest = 1'b1;
            end
            default: begin
                d.st              = ST_IDLE;
                d.rsp.waitrequest = 1'b1;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q.st              <= ST_IDLE;
            q.boot_done       <= 1'b0;
            q.rsp.readdata    <= '0;
            q.rsp.response    <= RESP_OKAY;
            q.rsp.waitrequest <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign avs_rsp = q.rsp;

    // ======================================================================
    // checks

    a_reset_level: assert property (@(posedge clk_sys) disable iff (!rstn)
        !q.boot_done |-> lvl_flat == {NUM_FIELDS{PRIO_RESET}})
        else $error("fields not at level four after reset");

    a_reset_enabled: assert property (@(posedge clk_sys) disable iff (!rstn)
        !q.boot_done |-> &fld_en && q.rsp.waitrequest)
        else $error("reset state wrong");

    a_unused_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        !q.rsp.waitrequest |-> q.rsp.readdata[DATA_W-1:REG_W] == '0
            && (q.rsp.readdata[REG_W-1:0] & ~REG_MASK[dec.idx]) == '0)
        else $error("unimplemented bits read as one");

    a_read_back: assert property (@(posedge clk_sys) disable iff (!rstn)
        !q.rsp.waitrequest && avs_req.read |-> q.rsp.readdata == rd_word)
        else $error("read data disagrees with fields");

    a_answer_one: assert property (@(posedge clk_sys) disable iff (!rstn)
        q.st == ST_IDLE && (avs_req.read || avs_req.write)
        |=> !q.rsp.waitrequest ##1 q.rsp.waitrequest)
        else $error("answer not one cycle after request");

    a_adc12_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        !q.rsp.waitrequest && avs_req.read && avs_req.address == OFS_ADC12
        |-> q.rsp.readdata[6:4] == levels.adc_p12_done_level)
        else $error("adc pair twelve field misplaced");

    a_pwm2_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_PWM12 && avs_req.byteenable[1]
        |=> levels.pwm_gen2_level == $past(avs_req.writedata[14:12]))
        else $error("pwm two field misplaced");

    a_pwm3_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_PWM3_6 && avs_req.byteenable[0]
        |=> levels.pwm_gen3_level == $past(avs_req.writedata[2:0]))
        else $error("pwm three field misplaced");

    a_cmp2_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_PWM7_CMP && avs_req.byteenable[1]
        |=> levels.comparator2_level == $past(avs_req.writedata[14:12]))
        else $error("comparator two field misplaced");

    a_cmp4_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_CMP34 && avs_req.byteenable[0]
        |=> levels.comparator4_level == $past(avs_req.writedata[6:4]))
        else $error("comparator four field misplaced");

    a_adc0_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_ADC01 && avs_req.byteenable[1]
        |=> levels.adc_p0_done_level == $past(avs_req.writedata[10:8]))
        else $error("adc pair zero field misplaced");

    a_adc5_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_ADC2_5 && avs_req.byteenable[1]
        |=> levels.adc_p5_done_level == $past(avs_req.writedata[14:12]))
        else $error("adc pair five field misplaced");

    // placement of the remaining fields on write
    a_pwm1_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_PWM12
            && avs_req.byteenable[1]
        |=> levels.pwm_gen1_level
            == $past(avs_req.writedata[10:8]))
        else $error("pwm one field misplaced");

    a_pwm4_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_PWM3_6
            && avs_req.byteenable[0]
        |=> levels.pwm_gen4_level
            == $past(avs_req.writedata[6:4]))
        else $error("pwm four field misplaced");

    a_pwm5_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_PWM3_6
            && avs_req.byteenable[1]
        |=> levels.pwm_gen5_level
            == $past(avs_req.writedata[10:8]))
        else $error("pwm five field misplaced");

    a_pwm6_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_PWM3_6
            && avs_req.byteenable[1]
        |=> levels.pwm_gen6_level
            == $past(avs_req.writedata[14:12]))
        else $error("pwm six field misplaced");

    a_pwm7_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_PWM7_CMP
            && avs_req.byteenable[0]
        |=> levels.pwm_gen7_level
            == $past(avs_req.writedata[2:0]))
        else $error("pwm seven field misplaced");

    a_pwm8_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_PWM7_CMP
            && avs_req.byteenable[0]
        |=> levels.pwm_gen8_level
            == $past(avs_req.writedata[6:4]))
        else $error("pwm eight field misplaced");

    a_pwm9_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_PWM7_CMP
            && avs_req.byteenable[1]
        |=> levels.pwm_gen9_level
            == $past(avs_req.writedata[10:8]))
        else $error("pwm nine field misplaced");

    a_cmp3_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_CMP34
            && avs_req.byteenable[0]
        |=> levels.comparator3_level
            == $past(avs_req.writedata[2:0]))
        else $error("comparator three field misplaced");

    a_adc1_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_ADC01
            && avs_req.byteenable[1]
        |=> levels.adc_p1_done_level
            == $past(avs_req.writedata[14:12]))
        else $error("adc pair one field misplaced");

    a_adc2_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_ADC2_5
            && avs_req.byteenable[0]
        |=> levels.adc_p2_done_level
            == $past(avs_req.writedata[2:0]))
        else $error("adc pair two field misplaced");

    a_adc3_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_ADC2_5
            && avs_req.byteenable[0]
        |=> levels.adc_p3_done_level
            == $past(avs_req.writedata[6:4]))
        else $error("adc pair three field misplaced");

    a_adc4_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_fire && avs_req.address == OFS_ADC2_5
            && avs_req.byteenable[1]
        |=> levels.adc_p4_done_level
            == $past(avs_req.writedata[10:8]))
        else $error("adc pair four field misplaced");

    // placement seen on the read path
    a_pwm1_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        !q.rsp.waitrequest && avs_req.read
            && avs_req.address == OFS_PWM12
        |-> q.rsp.readdata[10:8] == levels.pwm_gen1_level)
        else $error("pwm one field read misplaced");

    a_pwm6_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        !q.rsp.waitrequest && avs_req.read
            && avs_req.address == OFS_PWM3_6
        |-> q.rsp.readdata[14:12] == levels.pwm_gen6_level)
        else $error("pwm six field read misplaced");

    a_cmp3_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        !q.rsp.waitrequest && avs_req.read
            && avs_req.address == OFS_CMP34
        |-> q.rsp.readdata[2:0] == levels.comparator3_level)
        else $error("comparator three field read misplaced");

    a_adc1_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        !q.rsp.waitrequest && avs_req.read
            && avs_req.address == OFS_ADC01
        |-> q.rsp.readdata[14:12] == levels.adc_p1_done_level)
        else $error("adc pair one field read misplaced");

    a_no_stray_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        !wr_fire |=> $stable(lvl_flat))
        else $error("fields changed without accepted write");

endmodule
`default_nettype wire

// ==== testbench/test_ipb_prio_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_ipb_prio_bank;
    import ipb_pkg::*;

    // ==========================================================================
    // bench tables
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [BE_W-1:0]   be;
        logic [REG_W-1:0]  exp;
    } ipb_row_s;

    // implemented bits of each register
    localparam logic [15:0] MSK [7] = '{16'h0070, 16'h7700, 16'h7777, 16'h7777,
                                        16'h0077, 16'h7700, 16'h7777};
    // owning register and low bit of each source, in arbiter order
    localparam int FREG [19] = '{0, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 5, 5, 6, 6, 6, 6};
    localparam int FLSB [19] = '{4, 8, 12, 0, 4, 8, 12, 0, 4, 8, 12, 0, 4, 8, 12, 0, 4, 8, 12};

    // one write then readback per row
    localparam ipb_row_s ROWS [15] = '{
        '{5'h00, 32'hFFFFFFFF, 4'hF, 16'h0070},
        '{5'h04, 32'hFFFFFFFF, 4'hF, 16'h7700},
        '{5'h08, 32'hFFFFFFFF, 4'hF, 16'h7777},
        '{5'h0C, 32'hFFFFFFFF, 4'hF, 16'h7777},
        '{5'h10, 32'hFFFFFFFF, 4'hF, 16'h0077},
        '{5'h14, 32'hFFFFFFFF, 4'hF, 16'h7700},
        '{5'h18, 32'hFFFFFFFF, 4'hF, 16'h7777},
        '{5'h18, 32'hABCD4567, 4'hF, 16'h4567},
        '{5'h0C, 32'h00003210, 4'hF, 16'h3210},
        '{5'h08, 32'h00000000, 4'h1, 16'h7700},
        '{5'h14, 32'h00001111, 4'hF, 16'h1100},
        '{5'h04, 32'h00000000, 4'hF, 16'h0000},
        '{5'h10, 32'h00005500, 4'h2, 16'h0077},
        '{5'h00, 32'h00000010, 4'hF, 16'h0010},
        '{5'h00, 32'h00000000, 4'h0, 16'h0010}};

    // ==========================================================================
    // signals and design
    logic         clk_sys;
    logic         rstn;
    ipb_avs_req_s req;
    ipb_avs_rsp_s rsp;
    ipb_levels_s  lv;
    ipb_enables_t en;
    int           error_cnt;
    int           total_checks;
    logic [15:0]  img [7];
    logic [31:0]  rd;
    logic [1:0]   rs;

    ipb_prio_bank ipb_prio_bank_inst (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .avs_req     (req),
        .avs_rsp     (rsp),
        .levels      (lv),
        .src_enabled (en)
    );

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ==========================================================================
    // compare, model and bus tasks
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: data %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: response %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmp_lvl(input logic [56:0] got, input logic [56:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: levels %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmp_en(input logic [18:0] got, input logic [18:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: enables %0h expected %0h", $time, got, exp);
        end
    endtask

    // arbiter view expected from the register image
    task automatic check_outputs();
        logic [56:0] v;
        logic [18:0] e;
        for (int f = 0; f < 19; f++) begin
            v[f*3 +: 3] = img[FREG[f]][FLSB[f] +: 3];
            e[f]        = |img[FREG[f]][FLSB[f] +: 3];
        end
        cmp_lvl(lv, v);
        cmp_en(en, e);
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        req.address    <= a;
        req.read       <= ~wr;
        req.write      <= wr;
        req.byteenable <= be;
        req.writedata  <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 20);
        if (rsp.waitrequest !== 1'b0) begin
            error_cnt++;
            finish_test();
        end
        rd = rsp.readdata;
        rs = rsp.response;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk_sys);
    endtask

    // reset image, outputs and bus state while reset is held
    task automatic reset_expect();
        for (int i = 0; i < 7; i++) begin
            img[i] = MSK[i] & 16'h4444;
        end
        check_outputs();
        cmp_data({31'h0, rsp.waitrequest}, 32'h1);
    endtask

    task automatic read_all();
        for (int i = 0; i < 7; i++) begin
            bus(5'(i * 4), 1'b0, 32'h0, 4'hF);
            cmp_data(rd, {16'h0000, img[i]});
            cmp_resp(rs, RESP_OKAY);
        end
    endtask

    // ==========================================================================
    // watchdog
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end

    // ==========================================================================
    // main sequence
    initial begin
        rstn         = 1'b0;
        req          = '0;
        error_cnt    = 0;
        total_checks = 0;
        repeat (20) @(posedge clk_sys);
        reset_expect();
        rstn <= 1'b1;
        @(posedge clk_sys);
        read_all();
        // table of writes, each read back and seen by the arbiter
        for (int i = 0; i < 15; i++) begin
            bus(ROWS[i].addr, 1'b1, ROWS[i].wdata, ROWS[i].be);
            cmp_resp(rs, RESP_OKAY);
            img[ROWS[i].addr[4:2]] = ROWS[i].exp;
            check_outputs();
            bus(ROWS[i].addr, 1'b0, 32'h0, 4'hF);
            cmp_data(rd, {16'h0000, ROWS[i].exp});
            cmp_resp(rs, RESP_OKAY);
        end
        // unmapped and misaligned places refuse and change nothing
        bus(5'h1C, 1'b0, 32'h0, 4'hF);
        cmp_data(rd, 32'h0);
        cmp_resp(rs, RESP_DECERR);
        bus(5'h02, 1'b1, 32'hFFFFFFFF, 4'hF);
        cmp_resp(rs, RESP_DECERR);
        bus(5'h1C, 1'b1, 32'hFFFFFFFF, 4'hF);
        cmp_resp(rs, RESP_DECERR);
        check_outputs();
        // second reset in mid-run restores level four everywhere
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_expect();
        rstn <= 1'b1;
        @(posedge clk_sys);
        read_all();
        finish_test();
    end

endmodule
`default_nettype wire
